// >>> hdl/pmc_port_ctrl.sv
// Purpose: per-port mode and cycle settings of a four-port link master
// Assumes: single clock, byte-wide parameter data access, identity supplied by link logic
// Notes:   Function
// Function
// - each port keeps its own settings; one port's write leaves others untouched
// - mode byte: 0 off, 1 digital out, 2 digital in, 3 validated, 4 learning
// - disabled port: input data reads zero, line stays quiet
// - disabled port: its link indicator is dark
// - digital out: line follows bit 0 of the lowest output data byte
// - digital in: bit 0 of the lowest input data byte follows the line
// - validated mode: read identity, run link only when validation allows
// - policy byte: 0 unrestricted, 1 programmed period, 2 aligned over ports
// - unrestricted: cycle equals the minimum cycle the unit reported
// - programmed: cycle comes from the programmed cycle time
// - aligned: all ports start together, cycle is largest reported minimum
// - programmed cycle time matters only under the programmed policy
// - with validation, link starts only if identity matches expected values
// - level byte: 0 none, 1 vendor and device, 2 also serial number
// - validation applies only in validated mode
`timescale 1ns/10ps
module pmc_port_ctrl #(
    parameter int NP = pmc_pkg::NPORT
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          prm_wr,
    input  wire logic                          prm_rd,
    input  wire logic [15:0]                   prm_addr,
    input  wire logic [7:0]                    prm_wdata,
    output logic [7:0]                         prm_rdata,
    output logic                               prm_ack,
    output logic                               prm_err,
    input  wire logic [NP-1:0]                 learn_save,
    input  wire pmc_pkg::pmc_ident_t [NP-1:0]  id_data,
    input  wire logic [NP-1:0]                 id_valid,
    input  wire logic [NP-1:0][7:0]            min_cycle,
    input  wire logic [NP-1:0]                 pd_out_bit,
    input  wire logic [NP-1:0]                 cq_i,
    output logic [NP-1:0]                      cq_o,
    output logic [NP-1:0]                      cq_oe,
    output logic [NP-1:0]                      pd_in_bit,
    output logic [NP-1:0]                      pd_in_keep,
    output logic [NP-1:0]                      led_on,
    output logic [NP-1:0]                      comm_run,
    output logic [NP-1:0]                      msg_start,
    output logic [NP-1:0]                      id_req
);
    typedef struct packed {
        pmc_pkg::pmc_cfg_t   [NP-1:0]      cfg;
        pmc_pkg::pmc_ident_t [NP-1:0]      exp;
        logic [7:0]                        rdata;
        logic                              ack;
        logic                              err;
        logic [pmc_pkg::PRE_W-1:0]         pre;
        logic [7:0]                        scnt;
        logic [7:0]                        sper;
        logic                              stick;
    } pmc_top_t;

    pmc_top_t q;
    pmc_top_t next_q;

    always_comb begin
        logic        hit;
        logic        unit;
        logic [7:0]  big;
        logic [15:0] base;
        hit  = 1'b0;
        unit = 1'b0;
        big  = 8'h00;
        base = 16'h0000;
        next_q = q;
        next_q.ack   = 1'b0;
        next_q.err   = 1'b0;
        next_q.stick = 1'b0;
        // parameter data access, answered one cycle later
        for (int p = 0; p < NP; p++) begin
            base = 16'(p) * pmc_pkg::PORT_STRIDE;
            if (prm_addr == pmc_pkg::OFS_MODE + base) begin
                hit = 1'b1;
                next_q.rdata = q.cfg[p].mode;
                if (prm_wr) begin
                    next_q.cfg[p].mode = prm_wdata;
                end
            end
            if (prm_addr == pmc_pkg::OFS_POLICY + base) begin
                hit = 1'b1;
                next_q.rdata = q.cfg[p].policy;
                if (prm_wr) begin
                    next_q.cfg[p].policy = prm_wdata;
                end
            end
            if (prm_addr == pmc_pkg::OFS_PERIOD + base) begin
                hit = 1'b1;
                next_q.rdata = q.cfg[p].period;
                if (prm_wr) begin
                    next_q.cfg[p].period = prm_wdata;
                end
            end
            if (prm_addr == pmc_pkg::OFS_LEVEL + base) begin
                hit = 1'b1;
                next_q.rdata = q.cfg[p].level;
                if (prm_wr) begin
                    next_q.cfg[p].level = prm_wdata;
                end
            end
            // store the attached unit's identity as the expected one
            if (learn_save[p] && id_valid[p]
                && q.cfg[p].mode == pmc_pkg::LEARNING_COMM_MODE) begin
                next_q.exp[p] = id_data[p];
            end
            // largest reported minimum among aligned ports with a valid identity
            if (q.cfg[p].policy == pmc_pkg::ALIGNED_CYCLE && id_valid[p]
                && min_cycle[p] > big) begin
                big = min_cycle[p];
            end
        end
        if (prm_wr || prm_rd) begin
            next_q.ack = hit;
            next_q.err = !hit;
            if (!hit || prm_wr) begin
                next_q.rdata = 8'h00;
            end
        end else begin
            next_q.rdata = q.rdata;
        end
        // common message start for aligned ports
        next_q.sper = (big == 8'h00) ? 8'h01 : big;
        unit = (q.pre == pmc_pkg::PRE_LAST);
        next_q.pre = unit ? '0 : q.pre + 1'b1;
        if (unit) begin
            if (q.scnt + 8'h01 >= q.sper) begin
                next_q.scnt  = 8'h00;
                next_q.stick = 1'b1;
            end else begin
                next_q.scnt = q.scnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            for (int p = 0; p < NP; p++) begin
                q.cfg[p] <= '{pmc_pkg::RST_MODE, pmc_pkg::RST_POLICY,
                              pmc_pkg::RST_PERIOD, pmc_pkg::RST_LEVEL};
            end
            q.sper <= 8'h01;
        end else begin
            q <= next_q;
        end
    end

    assign prm_rdata = q.rdata;
    assign prm_ack   = q.ack;
    assign prm_err   = q.err;

    // one independent engine per port
    for (genvar g = 0; g < NP; g++) begin : g_port
        pmc_port_eng u_eng (
            .clk        (clk),
            .rst        (rst),
            .cfg        (q.cfg[g]),
            .exp_id     (q.exp[g]),
            .id_data    (id_data[g]),
            .id_valid   (id_valid[g]),
            .min_cycle  (min_cycle[g]),
            .sync_tick  (q.stick),
            .pd_out_bit (pd_out_bit[g]),
            .cq_i       (cq_i[g]),
            .cq_o       (cq_o[g]),
            .cq_oe      (cq_oe[g]),
            .pd_in_bit  (pd_in_bit[g]),
            .pd_in_keep (pd_in_keep[g]),
            .led_on     (led_on[g]),
            .comm_run   (comm_run[g]),
            .msg_start  (msg_start[g]),
            .id_req     (id_req[g])
        );
    end
endmodule

// >>> hdl/pmc_port_eng.sv
// Purpose: one master port: line mode, identity gate and message cycle timer
// Assumes: cfg is the programmed setting, taken over at a message start while the link runs, at once otherwise
// Notes:   all outputs are registered
`timescale 1ns/10ps
module pmc_port_eng (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire pmc_pkg::pmc_cfg_t   cfg,
    input  wire pmc_pkg::pmc_ident_t exp_id,
    input  wire pmc_pkg::pmc_ident_t id_data,
    input  wire logic              id_valid,
    input  wire logic [7:0]        min_cycle,
    input  wire logic              sync_tick,
    input  wire logic              pd_out_bit,
    input  wire logic              cq_i,
    output logic                   cq_o,
    output logic                   cq_oe,
    output logic                   pd_in_bit,
    output logic                   pd_in_keep,
    output logic                   led_on,
    output logic                   comm_run,
    output logic                   msg_start,
    output logic                   id_req
);
    typedef struct packed {
        pmc_pkg::pmc_st_t            st;
        pmc_pkg::pmc_cfg_t           act;
        logic                        s1;
        logic                        s2;
        logic [pmc_pkg::PRE_W-1:0]   pre;
        logic [7:0]                  cnt;
        logic                        cq_o;
        logic                        cq_oe;
        logic                        pd_in_bit;
        logic                        pd_in_keep;
        logic                        led_on;
        logic                        comm_run;
        logic                        msg_start;
        logic                        id_req;
    } pmc_eng_t;

    pmc_eng_t q;
    pmc_eng_t next_q;

    always_comb begin
        logic       unit;
        logic       fire;
        logic       ok;
        logic [7:0] per;
        unit = 1'b0;
        fire = 1'b0;
        ok   = 1'b0;
        per  = 8'h00;
        next_q = q;
        next_q.s1 = cq_i;
        next_q.s2 = q.s1;
        unit = (q.pre == pmc_pkg::PRE_LAST);
        next_q.pre = unit ? '0 : q.pre + 1'b1;
        per = (q.act.policy == pmc_pkg::PROGRAMMED_CYCLE) ? q.act.period
                                                          : min_cycle;
        if (per == 8'h00) begin
            per = 8'h01;
        end
        if (q.st == pmc_pkg::ST_COMM) begin
            if (q.act.policy == pmc_pkg::ALIGNED_CYCLE) begin
                // no second start right after one made under the old policy
                fire = sync_tick && !q.msg_start;
            end else begin
                fire = unit && (q.cnt + 8'h01 >= per);
            end
        end
        if (fire || q.st != pmc_pkg::ST_COMM) begin
            next_q.cnt = 8'h00;
        end else if (unit) begin
            next_q.cnt = q.cnt + 8'h01;
        end
        // settings change only between messages
        if (fire || q.st != pmc_pkg::ST_COMM) begin
            next_q.act = cfg;
        end
        case (next_q.act.level)
            pmc_pkg::NO_IDENTITY_CHECK:   ok = 1'b1;
            pmc_pkg::TYPE_IDENTITY_CHECK: ok = id_data.vendor == exp_id.vendor
                                            && id_data.device == exp_id.device;
            pmc_pkg::FULL_IDENTITY_CHECK: ok = id_data.vendor == exp_id.vendor
                                            && id_data.device == exp_id.device
                                            && id_data.serial == exp_id.serial;
            default:                      ok = 1'b0;
        endcase
        case (next_q.act.mode)
            pmc_pkg::MODE_PLAIN_OUTPUT:   next_q.st = pmc_pkg::ST_DOUT;
            pmc_pkg::PLAIN_INPUT_MODE:    next_q.st = pmc_pkg::ST_DIN;
            pmc_pkg::VALIDATED_COMM_MODE: next_q.st = (id_valid && ok)
                                                    ? pmc_pkg::ST_COMM : pmc_pkg::ST_IDENT;
            pmc_pkg::LEARNING_COMM_MODE:  next_q.st = pmc_pkg::ST_COMM;
            default:                      next_q.st = pmc_pkg::ST_OFF;
        endcase
        next_q.msg_start  = fire;
        next_q.cq_oe      = (next_q.st == pmc_pkg::ST_DOUT);
        next_q.cq_o       = (next_q.st == pmc_pkg::ST_DOUT) && pd_out_bit;
        next_q.pd_in_bit  = (next_q.st == pmc_pkg::ST_DIN) && q.s2;
        next_q.pd_in_keep = (next_q.st != pmc_pkg::ST_OFF);
        next_q.led_on     = (next_q.st == pmc_pkg::ST_COMM);
        next_q.comm_run   = (next_q.st == pmc_pkg::ST_COMM);
        next_q.id_req     = (next_q.st == pmc_pkg::ST_IDENT)
                         || (next_q.st == pmc_pkg::ST_COMM);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q     <= '0;
            q.st  <= pmc_pkg::ST_OFF;
            q.act <= '{pmc_pkg::RST_MODE, pmc_pkg::RST_POLICY,
                       pmc_pkg::RST_PERIOD, pmc_pkg::RST_LEVEL};
        end else begin
            q <= next_q;
        end
    end

    assign cq_o       = q.cq_o;
    assign cq_oe      = q.cq_oe;
    assign pd_in_bit  = q.pd_in_bit;
    assign pd_in_keep = q.pd_in_keep;
    assign led_on     = q.led_on;
    assign comm_run   = q.comm_run;
    assign msg_start  = q.msg_start;
    assign id_req     = q.id_req;
endmodule

// >>> inc/pmc_pkg.sv
// Purpose: shared constants and types for the port mode and cycle control block
// Assumes: 40 MHz system clock, byte-wide parameter data access
// Notes:   offsets are those of the first port; further ports follow at PORT_STRIDE
package pmc_pkg;
    localparam int          NPORT         = 4;
    // parameter data offsets of the first port
    localparam logic [15:0] OFS_MODE      = 16'h28a4;
    localparam logic [15:0] OFS_POLICY    = 16'h28a5;
    localparam logic [15:0] OFS_PERIOD    = 16'h28a6;
    localparam logic [15:0] OFS_LEVEL     = 16'h28aa;
    localparam logic [15:0] PORT_STRIDE   = 16'h0010;
    // values after reset
    localparam logic [7:0]  RST_MODE      = 8'h04;
    localparam logic [7:0]  RST_POLICY    = 8'h00;
    localparam logic [7:0]  RST_PERIOD    = 8'h14;
    localparam logic [7:0]  RST_LEVEL     = 8'h00;
    // line mode codes
    localparam logic [7:0]  MODE_DISABLED       = 8'h00;
    localparam logic [7:0]  MODE_PLAIN_OUTPUT   = 8'h01;
    localparam logic [7:0]  PLAIN_INPUT_MODE    = 8'h02;
    localparam logic [7:0]  VALIDATED_COMM_MODE = 8'h03;
    localparam logic [7:0]  LEARNING_COMM_MODE  = 8'h04;
    // cycle policy codes
    localparam logic [7:0]  UNRESTRICTED_CYCLE  = 8'h00;
    localparam logic [7:0]  PROGRAMMED_CYCLE    = 8'h01;
    localparam logic [7:0]  ALIGNED_CYCLE       = 8'h02;
    // validation level codes
    localparam logic [7:0]  NO_IDENTITY_CHECK   = 8'h00;
    localparam logic [7:0]  TYPE_IDENTITY_CHECK = 8'h01;
    localparam logic [7:0]  FULL_IDENTITY_CHECK = 8'h02;
    // cycle time unit and its length in clocks
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          CYCLE_UNIT_NS = 100000;
    localparam int          UNIT_TICKS    = CYCLE_UNIT_NS / CLK_PERIOD_NS;
    localparam int          PRE_W         = $clog2(UNIT_TICKS);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_TICKS - 1);

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] policy;
        logic [7:0] period;
        logic [7:0] level;
    } pmc_cfg_t;

    typedef struct packed {
        logic [15:0]  vendor;
        logic [31:0]  device;
        logic [127:0] serial;
    } pmc_ident_t;

    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_DOUT  = 5'h02,
        ST_DIN   = 5'h04,
        ST_IDENT = 5'h08,
        ST_COMM  = 5'h10
    } pmc_st_t;
endpackage

// >>> testbench/pmc_port_ctrl_checker.sv
// Purpose: concurrent checks on the ports of pmc_port_ctrl
// Assumes: one clock, rst synchronous active high
// Notes:   bound into every pmc_port_ctrl instance
`timescale 1ns/10ps
module pmc_port_ctrl_checker #(
    parameter int NP = 4
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          prm_wr,
    input wire logic          prm_rd,
    input wire logic [7:0]    prm_rdata,
    input wire logic          prm_ack,
    input wire logic          prm_err,
    input wire logic [NP-1:0] pd_out_bit,
    input wire logic [NP-1:0] cq_o,
    input wire logic [NP-1:0] cq_oe,
    input wire logic [NP-1:0] pd_in_bit,
    input wire logic [NP-1:0] pd_in_keep,
    input wire logic [NP-1:0] led_on,
    input wire logic [NP-1:0] comm_run,
    input wire logic [NP-1:0] msg_start,
    input wire logic [NP-1:0] id_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_req;
        prm_wr || prm_rd;
    endsequence
    sequence s_answer;
        prm_ack ^ prm_err;
    endsequence
    a_req_answer: assert property (s_req |=> s_answer)
        else $error("request without single answer");
    a_idle_quiet: assert property (!(prm_wr || prm_rd) |=> !(prm_ack || prm_err))
        else $error("answer without request");
    a_err_zero: assert property (prm_err |-> prm_rdata == 8'h00)
        else $error("refused request returned data");
    a_led_link: assert property (led_on == comm_run)
        else $error("indicator differs from link state");
    a_link_quiet: assert property ((comm_run & cq_oe) == '0)
        else $error("line driven while link runs");
    a_off_zero: assert property ((pd_in_bit & ~pd_in_keep) == '0)
        else $error("input bit set while data forced to zero");
    a_start_link: assert property ((msg_start & ~(comm_run | $past(comm_run))) == '0)
        else $error("message start without link");
    a_start_single: assert property ((msg_start & $past(msg_start)) == '0)
        else $error("message start longer than one cycle");
    a_dout_follow: assert property (((cq_oe & $past(cq_oe)) & (cq_o ^ $past(pd_out_bit))) == '0)
        else $error("output line does not follow output bit");
    a_link_ident: assert property ((comm_run & ~id_req) == '0)
        else $error("link runs without identity read");
endmodule

bind pmc_port_ctrl pmc_port_ctrl_checker #(.NP(NP)) chk_u (
    .clk(clk), .rst(rst), .prm_wr(prm_wr), .prm_rd(prm_rd), .prm_rdata(prm_rdata),
    .prm_ack(prm_ack), .prm_err(prm_err), .pd_out_bit(pd_out_bit), .cq_o(cq_o),
    .cq_oe(cq_oe), .pd_in_bit(pd_in_bit), .pd_in_keep(pd_in_keep), .led_on(led_on),
    .comm_run(comm_run), .msg_start(msg_start), .id_req(id_req)
);

// >>> testbench/pmc_unit_model.sv
// Purpose: field units on all ports: identity, reported cycle, line level
// Assumes: identity answer three clocks after the request
// Notes:   identity is inverted while not valid
`timescale 1ns/10ps
module pmc_unit_model #(
    parameter int NP = 4
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [NP-1:0]           id_req,
    input  wire logic [NP-1:0]           line_lvl,
    input  wire logic [NP-1:0]           cq_o,
    input  wire logic [NP-1:0]           cq_oe,
    output pmc_pkg::pmc_ident_t [NP-1:0] id_data,
    output logic [NP-1:0]                id_valid,
    output logic [NP-1:0][7:0]           min_cycle,
    output logic [NP-1:0]                cq_i
);
    logic [NP-1:0][1:0] wait_cnt;
    always_ff @(posedge clk) begin
        for (int p = 0; p < NP; p++) begin
            if (rst || !id_req[p])
                wait_cnt[p] <= 2'h0;
            else if (wait_cnt[p] != 2'h3)
                wait_cnt[p] <= wait_cnt[p] + 2'h1;
        end
    end
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            id_valid[p] = (wait_cnt[p] == 2'h3);
            // identity values are arbitrary
            id_data[p] = {16'h5a00 + 16'(p), 32'h0000_0100 + 32'(p), {8{16'h3130}}};
            if (!id_valid[p])
                id_data[p] = ~id_data[p];
            min_cycle[p] = 8'(p % 2 + 1);
            cq_i[p] = cq_oe[p] ? cq_o[p] : line_lvl[p];
        end
    end
endmodule

// >>> testbench/tb_pmc_port_ctrl.sv
// Purpose: self-checking bench of pmc_port_ctrl
// Assumes: unit model on the far side of all ports
// Notes:   full cycle unit, run of some 60k clocks
`timescale 1ns/10ps
module tb_pmc_port_ctrl;
    localparam int                NP = pmc_pkg::NPORT;
    logic                         clk = 1'b0, rst = 1'b1, prm_wr = 1'b0, prm_rd = 1'b0;
    logic [15:0]                  prm_addr = 16'h0000;
    logic [7:0]                   prm_wdata = 8'h00, prm_rdata, q;
    logic                         prm_ack, prm_err;
    logic [1:0]                   ans;
    logic [NP-1:0]                learn_save = '0, pd_out_bit = '0, line_lvl = '0;
    logic [NP-1:0]                id_valid, cq_i, cq_o, cq_oe, pd_in_bit, pd_in_keep;
    logic [NP-1:0]                led_on, comm_run, msg_start, id_req;
    logic [NP-1:0][7:0]           min_cycle;
    pmc_pkg::pmc_ident_t [NP-1:0] id_data;
    int                           n_mismatch = 0, check_count = 0;
    always #12.5 clk = ~clk;
    pmc_port_ctrl #(.NP(NP)) dut_u (.clk(clk), .rst(rst), .prm_wr(prm_wr), .prm_rd(prm_rd),
        .prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata), .prm_ack(prm_ack),
        .prm_err(prm_err), .learn_save(learn_save), .id_data(id_data), .id_valid(id_valid),
        .min_cycle(min_cycle), .pd_out_bit(pd_out_bit), .cq_i(cq_i), .cq_o(cq_o),
        .cq_oe(cq_oe), .pd_in_bit(pd_in_bit), .pd_in_keep(pd_in_keep), .led_on(led_on),
        .comm_run(comm_run), .msg_start(msg_start), .id_req(id_req));
    pmc_unit_model #(.NP(NP)) unit_u (.clk(clk), .rst(rst), .id_req(id_req),
        .line_lvl(line_lvl), .cq_o(cq_o), .cq_oe(cq_oe), .id_data(id_data),
        .id_valid(id_valid), .min_cycle(min_cycle), .cq_i(cq_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic acc(input logic w, input int p, input logic [15:0] ofs, input logic [7:0] d);
        idle(1);
        prm_wr = w;
        prm_rd = !w;
        prm_addr = ofs + 16'(p) * pmc_pkg::PORT_STRIDE;
        prm_wdata = d;
        idle(1);
        prm_wr = 1'b0;
        prm_rd = 1'b0;
        q = prm_rdata;
        ans = {prm_err, prm_ack};
    endtask
    task automatic put(input int p, input logic [15:0] ofs, input logic [7:0] d);
        acc(1'b1, p, ofs, d);
        chk(ans, 2'b01);
    endtask
    task automatic rd(input int p, input logic [15:0] ofs, input logic [7:0] e);
        acc(1'b0, p, ofs, 8'h00);
        chk(ans, 2'b01);
        chk(q, e);
    endtask
    // waits for a message start; a missing one counts as a mismatch
    task automatic wait_start(input int p);
        int c;
        c = 0;
        while (msg_start[p] !== 1'b1 && c < 20000) begin
            idle(1);
            c++;
        end
        chk(msg_start[p], 1'b1);
    endtask
    // waits for a message start, then counts to the next one
    task automatic gap(input int p, input int units);
        int c;
        wait_start(p);
        c = 0;
        do begin
            idle(1);
            c++;
        end while (msg_start[p] !== 1'b1 && c < 20000);
        chk(msg_start[p], 1'b1);
        if (units != 0)
            chk(c, units * pmc_pkg::UNIT_TICKS);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(100000 * 25);
        n_mismatch++;
        results();
    end
    initial begin
        idle(12);
        rst = 1'b0;
        for (int p = 0; p < NP; p++) begin
            rd(p, 16'h28a4, 8'h04);
            rd(p, 16'h28a5, 8'h00);
            rd(p, 16'h28a6, 8'h14);
            rd(p, 16'h28aa, 8'h00);
        end
        acc(1'b0, 0, 16'h28a7, 8'h00);
        chk({ans, q}, 10'h200);
        chk({comm_run, led_on, id_req}, 12'hfff);
        fin("reset");
        put(1, 16'h28a4, 8'h00);
        chk(comm_run[1], 1'b1);
        wait_start(1);
        idle(3);
        chk({comm_run, led_on}, 8'hdd);
        chk({pd_in_keep[1], cq_oe[1]}, 2'b00);
        rd(0, 16'h28a4, 8'h04);
        fin("disable");
        put(1, 16'h28a4, 8'h01);
        pd_out_bit[1] = 1'b1;
        idle(3);
        chk({cq_oe[1], cq_o[1]}, 2'b11);
        pd_out_bit[1] = 1'b0;
        idle(3);
        chk({cq_oe[1], cq_o[1]}, 2'b10);
        put(1, 16'h28a4, 8'h02);
        line_lvl[1] = 1'b1;
        idle(5);
        chk({cq_oe[1], pd_in_keep[1], pd_in_bit[1]}, 3'b011);
        line_lvl[1] = 1'b0;
        idle(5);
        chk(pd_in_bit[1], 1'b0);
        fin("plain");
        put(1, 16'h28aa, 8'h01);
        put(1, 16'h28a4, 8'h03);
        idle(10);
        chk({comm_run[1], id_req[1]}, 2'b01);
        put(1, 16'h28a4, 8'h04);
        idle(4);
        chk(comm_run[1], 1'b1);
        learn_save[2] = 1'b1;
        idle(1);
        learn_save[2] = 1'b0;
        put(2, 16'h28aa, 8'h02);
        put(2, 16'h28a4, 8'h03);
        wait_start(2);
        idle(6);
        chk(comm_run[2], 1'b1);
        fin("validation");
        put(0, 16'h28a6, 8'h03);
        wait_start(0);
        gap(0, 1);
        put(0, 16'h28a5, 8'h01);
        wait_start(0);
        gap(0, 3);
        put(0, 16'h28a5, 8'h02);
        put(3, 16'h28a5, 8'h02);
        wait_start(0);
        gap(0, 0);
        gap(0, 2);
        chk(msg_start[3], 1'b1);
        fin("cycle");
        results();
    end
endmodule
